// ===== core/dsp_engine.sv
// One signal-processing engine: sequencer, SIMD ALU, packed MAC, FPU and local storage
`timescale 1ns/1ps
module dsp_engine
  import dsp_engine_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire logic              pm_we,
  input  wire logic [PM_AW-1:0]  pm_waddr,
  input  wire logic [PM_W-1:0]   pm_wdata,
  input  wire logic [REG_AW-1:0] dbg_raddr,
  output logic      [DATA_W-1:0] dbg_rdata,
  output logic      [DATA_W-1:0] dm_addr,
  output logic      [DATA_W-1:0] dm_wdata,
  output logic                   dm_we,
  output logic                   dm_re,
  input  wire logic [DATA_W-1:0] dm_rdata,
  output logic                   busy,
  output logic      [PM_AW-1:0]  pc
);
  // ----------------------------------------------------------------
  // Storage and control state
  // ----------------------------------------------------------------
  logic [PM_W-1:0]   pm_q   [PM_N];
  logic [DATA_W-1:0] regs_q [REG_N];
  logic [DATA_W-1:0] fpr_q  [FPR_N];
  logic [DATA_W-1:0] acc_q  [MAC_N];
  logic [DATA_W-1:0] acc_nx [MAC_N];
  state_t            st_q;
  logic [PM_W-1:0]   ir_q;
  logic [PM_AW-1:0]  pc_q;
  logic [REG_AW-1:0] ld_idx_q;
  logic [DATA_W-1:0] dbg_q, dm_addr_q, dm_wdata_q;
  logic              dm_we_q, dm_re_q;

  // Decode fields of the instruction in flight
  op_t               op;
  logic [1:0]        w;
  logic [REG_AW-1:0] ra, rb;
  logic [DATA_W-1:0] op_a, op_b;
  logic              w8, w16, w32, ex;
  assign op   = op_t'(ir_q[OP_LSB+:4]);
  assign w    = ir_q[W_LSB+:2];
  assign ra   = ir_q[RA_LSB+:REG_AW];
  assign rb   = ir_q[RB_LSB+:REG_AW];
  assign op_a = regs_q[ra];
  assign op_b = regs_q[rb];
  assign w8   = (w == W8);
  assign w16  = (w == W16);
  assign w32  = !w8 && !w16;
  assign ex   = (st_q == ST_EXEC);

  // ----------------------------------------------------------------
  // Per byte lane: adder, shifter, absolute difference
  // ----------------------------------------------------------------
  logic [LANES-1:0]  cy;
  logic [DATA_W-1:0] sum, sh8, sh16, sh32;
  logic [7:0]        ad [LANES];
  logic              sub, left;
  assign sub  = (op == OP_SUB);
  assign left = (op == OP_SHL);
  assign sh32 = left ? op_a << op_b[4:0] : op_a >> op_b[4:0];
  for (genvar i = 0; i < LANES; i++) begin : g_byte
    logic [7:0] a8, b8;
    logic       cin;
    assign a8 = op_a[i*8+:8];
    assign b8 = op_b[i*8+:8];
    // Carry into a lane is cut at the active partition edge
    if (i == 0) begin : g_c0
      assign cin = sub;
    end else if (i == 2) begin : g_c2
      assign cin = w32 ? cy[i-1] : sub;
    end else begin : g_cx
      assign cin = !w8 ? cy[i-1] : sub;
    end
    assign {cy[i], sum[i*8+:8]} = {1'b0, a8} + {1'b0, b8 ^ {8{sub}}} + {8'h00, cin};
    // Shift bits fall off the lane edge rather than into a neighbour
    assign sh8[i*8+:8] = left ? a8 << op_b[2:0] : a8 >> op_b[2:0];
    if (i % 2 == 0) begin : g_h
      assign sh16[i*8+:16] = left ? op_a[i*8+:16] << op_b[3:0] : op_a[i*8+:16] >> op_b[3:0];
    end
    assign ad[i] = (a8 > b8) ? a8 - b8 : b8 - a8;
  end

  // ----------------------------------------------------------------
  // Packed MAC: outer product of lanes, one accumulator per product
  // ----------------------------------------------------------------
  logic [MAC_N-1:0] lane_en;
  for (genvar j = 0; j < MAC_N; j++) begin : g_mac
    logic [15:0]       p8;
    logic [DATA_W-1:0] p16, p32, prod;
    assign p8 = op_a[(j/4)*8+:8] * op_b[(j%4)*8+:8];
    if (j < 4) begin : g_p16
      assign p16 = op_a[(j/2)*16+:16] * op_b[(j%2)*16+:16];
    end else begin : g_n16
      assign p16 = '0;
    end
    if (j == 0) begin : g_p32
      assign p32 = op_a * op_b;
    end else begin : g_n32
      assign p32 = '0;
    end
    // Width picks 16, 4 or 1 active products per cycle
    assign lane_en[j] = w8 || (w16 && j < 4) || (w32 && j == 0);
    assign prod       = w8 ? {16'h0000, p8} : (w16 ? p16 : p32);
    assign acc_nx[j]  = acc_q[j] + prod;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        acc_q[j] <= '0;
      end else if (ex && op == OP_MAC && lane_en[j]) begin
        acc_q[j] <= acc_nx[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Fused floating multiply-add; truncates, so not IEEE rounding
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] fp_fmac(input logic [DATA_W-1:0] acc,
                                                input logic [DATA_W-1:0] x,
                                                input logic [DATA_W-1:0] y);
    logic [47:0] pm;
    logic [23:0] mp, ma, mb, ms;
    logic [24:0] s;
    logic signed [9:0] ep, ea, eb, es, dif;
    logic sp, sb, abig;
    pm = {1'b1, x[22:0]} * {1'b1, y[22:0]}; // 24-bit mantissa multiplier
    ep = $signed({2'b00, x[30:23]}) + $signed({2'b00, y[30:23]}) - FP_BIAS;
    if (pm[47]) begin
      mp = pm[47:24];
      ep = ep + FP_ONE;
    end else begin
      mp = pm[46:23];
    end
    if (x[30:23] == 8'h00 || y[30:23] == 8'h00) begin
      mp = '0;
    end
    sp   = x[31] ^ y[31];
    ma   = (acc[30:23] == 8'h00) ? 24'h000000 : {1'b1, acc[22:0]};
    ea   = $signed({2'b00, acc[30:23]});
    abig = (mp == '0) || (ma != '0 && (ea > ep || (ea == ep && ma >= mp)));
    eb   = abig ? ea : ep;
    es   = abig ? ep : ea;
    mb   = abig ? ma : mp;
    ms   = abig ? mp : ma;
    sb   = abig ? acc[31] : sp;
    dif  = eb - es;
    ms   = (dif > FP_DIF_MAX || dif < 0) ? 24'h000000 : ms >> dif[4:0];
    // Same signs add magnitudes, opposite signs subtract the smaller
    if (acc[31] == sp) begin
      s = {1'b0, mb} + {1'b0, ms};
      if (s[24]) begin
        s  = s >> 1;
        eb = eb + FP_ONE;
      end
    end else begin
      s = {1'b0, mb - ms};
    end
    for (int k = 0; k < FP_MANT_W; k++) begin
      if (!s[23] && s != '0) begin
        s  = s << 1;
        eb = eb - FP_ONE;
      end
    end
    if (s == '0) begin
      return '0;
    end else if (eb <= 0) begin
      return {sb, 31'h00000000};
    end else if (eb >= FP_EXP_MAX) begin
      return {sb, 8'hff, 23'h000000};
    end
    return {sb, eb[7:0], s[22:0]};
  endfunction

  // ----------------------------------------------------------------
  // Result select and register write port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] res, mac_sum, fmask, wr_data;
  logic [9:0]        ad_sum;
  logic              wr_en;
  logic [REG_AW-1:0] wr_idx;
  always_comb begin
    mac_sum = '0;
    for (int k = 0; k < MAC_N; k++) begin
      mac_sum = mac_sum + acc_nx[k];
    end
    ad_sum = {2'b00, ad[0]} + {2'b00, ad[1]} + {2'b00, ad[2]} + {2'b00, ad[3]};
    fmask = (op_b[9:5] == 5'h00) ? 32'hffffffff : ~(32'hffffffff << op_b[9:5]);
    case (op)
      OP_ADD, OP_SUB: res = sum; // Lanes packed into one word
      OP_AND:         res = op_a & op_b;
      OP_OR:          res = op_a | op_b;
      OP_XOR:         res = op_a ^ op_b;
      OP_SHL, OP_SHR: res = w8 ? sh8 : (w16 ? sh16 : sh32);
      OP_FEXT:        res = (op_a >> op_b[4:0]) & fmask;
      OP_MAC:         res = mac_sum;
      OP_ABS_DIFF_SUM: res = {22'h000000, ad_sum};
      OP_FST:         res = fpr_q[rb[1:0]];
      default:        res = op_a;
    endcase
  end
  assign wr_en   = (ex && op != OP_LD && op != OP_ST && op != OP_BRZ && op != OP_FLD
                    && op != OP_FMAC) || (st_q == ST_LOAD);
  assign wr_idx  = (st_q == ST_LOAD) ? ld_idx_q : ra;
  assign wr_data = (st_q == ST_LOAD) ? dm_rdata : res;

  // Register store, no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  // Floating-point register file; FMAC: f[w] += f[ra] * f[rb]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < FPR_N; k++) begin
        fpr_q[k] <= '0;
      end
    end else if (ex && op == OP_FLD) begin
      fpr_q[rb[1:0]] <= op_a;
    end else if (ex && op == OP_FMAC) begin
      fpr_q[w] <= fp_fmac(fpr_q[w], fpr_q[ra[1:0]], fpr_q[rb[1:0]]);
    end
  end

  // Program memory load port; a fetch in the same cycle reads the old word
  always_ff @(posedge clk) begin
    if (pm_we) begin
      pm_q[pm_waddr] <= pm_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: fetch, execute, optional load capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q     <= ST_IDLE;
      pc_q     <= '0;
      ir_q     <= '0;
      ld_idx_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (run) begin
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          ir_q <= pm_q[pc_q];
          st_q <= ST_EXEC;
        end
        ST_EXEC: begin
          pc_q     <= (op == OP_BRZ && op_a == '0) ? {w[0], rb, 1'b0} : pc_q + 1'b1;
          ld_idx_q <= ra;
          st_q     <= (op == OP_LD) ? ST_LOAD : (run ? ST_FETCH : ST_IDLE);
        end
        ST_LOAD: begin
          st_q <= run ? ST_FETCH : ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Data memory strobes: write is one pulse, read stands through capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      dm_addr_q  <= '0;
      dm_wdata_q <= '0;
    end else begin
      dm_we_q <= ex && op == OP_ST;
      dm_re_q <= ex && op == OP_LD;
      if (ex && (op == OP_LD || op == OP_ST)) begin
        dm_addr_q  <= op_b;
        dm_wdata_q <= op_a;
      end
    end
  end

  // Debug read of the register store, one cycle latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dbg_q <= '0;
    end else begin
      dbg_q <= regs_q[dbg_raddr];
    end
  end

  assign dbg_rdata = dbg_q;
  assign dm_addr   = dm_addr_q;
  assign dm_wdata  = dm_wdata_q;
  assign dm_we     = dm_we_q;
  assign dm_re     = dm_re_q;
  assign busy      = (st_q != ST_IDLE);
  assign pc        = pc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Plain nets for the checks, so past values are only taken of whole signals
  logic [1:0]        fa, fb;
  logic [DATA_W-1:0] f_acc;
  logic [PM_W-1:0]   pm_rd;
  logic [PM_AW-1:0]  br_tgt;
  assign fa     = ra[1:0];
  assign fb     = rb[1:0];
  assign f_acc  = fpr_q[w];
  assign pm_rd  = pm_q[pc_q];
  assign br_tgt = {w[0], rb, 1'b0};

  sequence s_exec(op_t o, logic [1:0] wd);
    ex && op == o && w == wd;
  endsequence
  a_add_full_word: assert property (@(posedge clk) disable iff (!rst_n)
    s_exec(OP_ADD, 2'h2) |-> wr_en && wr_idx == ra && wr_data == op_a + op_b)
    else $error("32-bit add result wrong");
  a_byte_sub_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    s_exec(OP_SUB, W8) |-> wr_data == {op_a[31:24] - op_b[31:24],
      op_a[23:16] - op_b[23:16], op_a[15:8] - op_b[15:8], op_a[7:0] - op_b[7:0]})
    else $error("byte-lane subtract wrong");
  a_byte_add_pack: assert property (@(posedge clk) disable iff (!rst_n)
    s_exec(OP_ADD, W8) |-> wr_data[31:24] == op_a[31:24] + op_b[31:24])
    else $error("top byte lane not packed");
  a_half_no_carry: assert property (@(posedge clk) disable iff (!rst_n)
    s_exec(OP_ADD, W16) |-> wr_data[31:16] == op_a[31:16] + op_b[31:16])
    else $error("carry crossed half lane");
  a_shift_byte_lane: assert property (@(posedge clk) disable iff (!rst_n)
    s_exec(OP_SHL, W8) |-> wr_data[15:8] == op_a[15:8] << op_b[2:0])
    else $error("byte shift leaked");
  a_mac_lane_count: assert property (@(posedge clk) disable iff (!rst_n)
    (ex && op == OP_MAC) |-> $countones(lane_en) == (w8 ? 16 : (w16 ? 4 : 1)))
    else $error("MAC lane count wrong");
  a_abs_diff_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ex && op == OP_ABS_DIFF_SUM && op_a == op_b) |-> wr_data == '0)
    else $error("difference sum of equal operands not zero");
  a_fp_reg_load: assert property (@(posedge clk) disable iff (!rst_n)
    (ex && op == OP_FLD) |=> fpr_q[$past(fb)] == $past(op_a))
    else $error("FP register load wrong");
  a_fmac_zero_prod: assert property (@(posedge clk) disable iff (!rst_n)
    (ex && op == OP_FMAC && fpr_q[fa] == '0 && f_acc[30:23] != 8'h00)
      |=> fpr_q[$past(w)] == $past(f_acc))
    else $error("FMAC with zero product changed sum");
  a_load_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == ST_LOAD) |-> dm_re ##1 regs_q[$past(ld_idx_q)] == $past(dm_rdata))
    else $error("load not written to register");
  a_fetch_then_exec: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == ST_FETCH && !pm_we) |=> ex && ir_q == $past(pm_rd))
    else $error("fetch did not load instruction");
  a_branch_target: assert property (@(posedge clk) disable iff (!rst_n)
    (ex && op == OP_BRZ && op_a == '0) |=> pc_q == $past(br_tgt) && !ex)
    else $error("branch target wrong");
endmodule

// ===== core/dsp_engine_pkg.sv
// Constants, encodings and state type shared by the signal-processing engine datapath
package dsp_engine_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int REG_N   = 128;
  localparam int REG_AW  = 7;
  localparam int PM_N    = 512;
  localparam int PM_AW   = 9;
  localparam int PM_W    = 20;
  localparam int FPR_N   = 4;
  localparam int LANES   = 4;
  localparam int MAC_N   = 16;
  // ----------------------------------------------------------------
  // Instruction word: op[19:16] w[15:14] ra[13:7] rb[6:0]
  // ----------------------------------------------------------------
  localparam int OP_LSB  = 16;
  localparam int W_LSB   = 14;
  localparam int RA_LSB  = 7;
  localparam int RB_LSB  = 0;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
    OP_XOR = 4'h4, OP_SHL = 4'h5, OP_SHR = 4'h6, OP_FEXT = 4'h7,
    OP_LD = 4'h8, OP_ST = 4'h9, OP_BRZ = 4'ha, OP_MAC = 4'hb,
    OP_ABS_DIFF_SUM = 4'hc, OP_FMAC = 4'hd, OP_FLD = 4'he, OP_FST = 4'hf
  } op_t;
  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  // ----------------------------------------------------------------
  // Floating point, single precision, truncating, denormals flushed
  // ----------------------------------------------------------------
  localparam int FP_MANT_W = 24;
  localparam logic signed [9:0] FP_BIAS    = 10'sh07f;
  localparam logic signed [9:0] FP_EXP_MAX = 10'sh0ff;
  localparam logic signed [9:0] FP_ONE     = 10'sh001;
  localparam logic signed [9:0] FP_DIF_MAX = 10'sh017;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_FETCH = 4'h2, ST_EXEC = 4'h4, ST_LOAD = 4'h8
  } state_t;
endpackage

// ===== tb/test_simd_dsp_engine_datapath.sv
// Self-checking testbench for the signal-processing engine datapath
`timescale 1ns/1ps
module test_simd_dsp_engine_datapath
  import dsp_engine_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              run;
  logic              pm_we;
  logic [PM_AW-1:0]  pm_waddr;
  logic [PM_W-1:0]   pm_wdata;
  logic [REG_AW-1:0] dbg_raddr;
  logic [DATA_W-1:0] dbg_rdata;
  logic [DATA_W-1:0] dm_addr;
  logic [DATA_W-1:0] dm_wdata;
  logic              dm_we;
  logic              dm_re;
  logic [DATA_W-1:0] dm_rdata;
  logic              busy;
  logic [PM_AW-1:0]  pc;
  logic [31:0]       ld_val;
  logic [31:0]       mdl [REG_N];
  logic [31:0]       acc [MAC_N];
  logic [31:0]       fm [FPR_N];
  logic [8:0]        pc_m;
  int                err_total;
  int                checked;
  int                we_cnt;
  int                re_cnt;
  int                seed;

  dsp_engine DUT (.clk(clk), .rst_n(rst_n), .run(run), .pm_we(pm_we), .pm_waddr(pm_waddr),
    .pm_wdata(pm_wdata), .dbg_raddr(dbg_raddr), .dbg_rdata(dbg_rdata), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata), .busy(busy),
    .pc(pc));

  // ----------------------------------------------------------------
  // Clock, memory stand-in and strobe counters
  // ----------------------------------------------------------------
  // 10 MHz clock
  always #50 clk = ~clk;
  // Inverted data outside a read so a stale value never looks right
  assign dm_rdata = dm_re ? ld_val : ~ld_val;
  // Count strobes so a doubled or missing pulse shows up
  always @(posedge clk) begin
    if (dm_we === 1'b1) we_cnt++;
    if (dm_re === 1'b1) re_cnt++;
  end

  // ----------------------------------------------------------------
  // Expectations and checking
  // ----------------------------------------------------------------
  // Lane-wise reference for ALU, field extract and byte difference sum
  function automatic logic [31:0] alu_exp(input logic [3:0] op, input logic [1:0] w,
                                          input logic [31:0] a, input logic [31:0] b);
    int          lw;
    logic [31:0] m, x, y, r, res;
    logic [4:0]  len;
    lw = (w == W8) ? 8 : (w == W16) ? 16 : 32;
    m = (lw == 32) ? 32'hffffffff : ((32'h1 << lw) - 32'h1);
    res = 32'h0;
    len = b[9:5];
    if (op == OP_FEXT)
      return (a >> b[4:0]) & ((len == 0) ? 32'hffffffff : ((32'h1 << len) - 32'h1));
    if (op == OP_ABS_DIFF_SUM) begin
      for (int k = 0; k < 4; k++) begin
        x = (a >> (k * 8)) & 32'hff;
        y = (b >> (k * 8)) & 32'hff;
        res += (x > y) ? x - y : y - x;
      end
      return res;
    end
    // Each lane masked on its own, so no carry leaks to the next one
    for (int k = 0; k < 32 / lw; k++) begin
      x = (a >> (k * lw)) & m;
      y = (b >> (k * lw)) & m;
      case (op)
        OP_ADD:  r = x + y;
        OP_SUB:  r = x - y;
        OP_AND:  r = x & y;
        OP_OR:   r = x | y;
        OP_XOR:  r = x ^ y;
        OP_SHL:  r = x << (b & (lw - 1));
        default: r = x >> (b & (lw - 1));
      endcase
      res |= (r & m) << (k * lw);
    end
    return res;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Debug port answers one edge after the address is set
  task automatic chk_val(input logic [6:0] idx, input logic [31:0] exp);
    dbg_raddr = idx;
    @(posedge clk);
    #1;
    check(dbg_rdata, exp);
  endtask

  task automatic chk_reg(input logic [6:0] idx);
    chk_val(idx, mdl[idx]);
  endtask

  // ----------------------------------------------------------------
  // Run one instruction from the program store and update the model
  // ----------------------------------------------------------------
  task automatic exec(input logic [3:0] op, input logic [1:0] w, input logic [6:0] ra,
                      input logic [6:0] rb);
    logic [31:0] a, b, s;
    logic [8:0]  pc_e;
    int          we0, re0;
    a = mdl[ra];
    b = mdl[rb];
    we0 = we_cnt;
    re0 = re_cnt;
    pc_e = pc_m + 9'h1;
    pm_we = 1'b1;
    pm_waddr = pc_m;
    pm_wdata = {op, w, ra, rb};
    @(posedge clk);
    #1;
    pm_we = 1'b0;
    run = 1'b1;
    @(posedge clk);
    #1;
    run = 1'b0;
    for (int i = 0; i < 10 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check(busy, 32'h0);
    case (op)
      OP_LD: begin
        mdl[ra] = ld_val;
        check(dm_addr, b);
        check(re_cnt - re0, 32'h1);
      end
      OP_ST: begin
        check(dm_addr, b);
        check(dm_wdata, a);
        check({31'h0, dm_we}, 32'h1);
        // The strobe is counted at the edge that ends it
        @(posedge clk);
        #1;
        check(we_cnt - we0, 32'h1);
      end
      OP_BRZ: if (a == 32'h0) pc_e = {w[0], rb, 1'b0};
      OP_MAC: begin
        s = 32'h0;
        for (int i = 0; i < 16; i++) begin
          if (w == W8) acc[i] += a[8 * (i / 4) +: 8] * b[8 * (i % 4) +: 8];
          else if (w == W16 && i < 4) acc[i] += a[16 * (i / 2) +: 16] * b[16 * (i % 2) +: 16];
          else if (w[1] && i == 0) acc[0] += a * b;
          s += acc[i];
        end
        mdl[ra] = s;
      end
      OP_FLD:  fm[rb[1:0]] = a;
      OP_FST:  mdl[ra] = fm[rb[1:0]];
      OP_FMAC: ;
      default: mdl[ra] = alu_exp(op, w, a, b);
    endcase
    pc_m = pc_e;
    check({23'h0, pc}, {23'h0, pc_m});
  endtask

  task automatic tally_and_finish;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog: the tests need well under a millisecond
  initial begin
    #3000000;
    err_total++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] op;
    logic [6:0] ra;
    clk = 1'b0;
    rst_n = 1'b0;
    run = 1'b0;
    pm_we = 1'b0;
    pm_waddr = 9'h0;
    pm_wdata = 20'h0;
    dbg_raddr = 7'h0;
    ld_val = 32'h0;
    pc_m = 9'h0;
    seed = 17666;
    foreach (acc[i]) acc[i] = 32'h0;
    foreach (fm[i]) fm[i] = 32'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({23'h0, pc}, 32'h0);
    check({dm_we, dm_re, busy}, 32'h0);
    check(dm_addr | dm_wdata, 32'h0);
    // Cleared FP register gives the first known integer value
    exec(OP_FST, W8, 7'h0, 7'h0);
    chk_reg(7'h0);
    for (int i = 1; i < 12; i++) begin
      ld_val = $random(seed);
      if (i == 9) ld_val = {4{ld_val[7:0]}};
      if (i == 10) ld_val = 32'h00010203;
      if (i == 11) ld_val = 32'h01010101;
      exec(OP_LD, W8, 7'(i), 7'h0);
      chk_reg(7'(i));
    end
    // Byte lanes borrow on their own and pack into one word
    exec(OP_SUB, W8, 7'ha, 7'hb);
    chk_val(7'ha, 32'hff000102);
    exec(OP_ABS_DIFF_SUM, W8, 7'ha, 7'hb);
    chk_val(7'ha, 32'h00000100);
    // Random lane operations; shifts use a replicated amount word
    for (int n = 0; n < 60; n++) begin
      if (n % 10 == 0) begin
        ld_val = $random(seed);
        exec(OP_LD, W8, 7'(1 + n % 8), 7'h0);
      end
      op = 4'($unsigned($random(seed)) % 8);
      if (n % 8 == 7) op = OP_ABS_DIFF_SUM;
      ra = 7'(1 + $unsigned($random(seed)) % 8);
      exec(op, 2'($random(seed)), ra,
           (op == OP_SHL || op == OP_SHR) ? 7'h9 : 7'(1 + $unsigned($random(seed)) % 8));
      chk_reg(ra);
    end
    // Equal operands give a zero difference sum; the amount word is no longer needed
    exec(OP_ABS_DIFF_SUM, W8, 7'h9, 7'h9);
    chk_val(7'h9, 32'h0);
    // Multiply-accumulate over all three widths, back to back
    for (int n = 0; n < 9; n++) begin
      exec(OP_MAC, 2'(n % 3), 7'(1 + n % 8), 7'(2 + n % 7));
      chk_reg(7'(1 + n % 8));
    end
    exec(OP_ST, W8, 7'h3, 7'h4);
    // Taken branch to {w0, rb, 0}, then a branch that falls through
    exec(OP_BRZ, W16, 7'h0, 7'h15);
    check({23'h0, pc}, 32'h12a);
    exec(OP_BRZ, W8, 7'hb, 7'h15);
    // Fused FP multiply-accumulate: 0 + 2*3 + 2*3 = 12.0
    ld_val = 32'h40000000;
    exec(OP_LD, W8, 7'hd, 7'h0);
    ld_val = 32'h40400000;
    exec(OP_LD, W8, 7'he, 7'h0);
    exec(OP_FLD, W8, 7'hd, 7'h1);
    exec(OP_FLD, W8, 7'he, 7'h3);
    exec(OP_FMAC, 2'h2, 7'h1, 7'h3);
    exec(OP_FMAC, 2'h2, 7'h1, 7'h3);
    // A zero product from the still cleared register 0 leaves the sum alone
    exec(OP_FMAC, 2'h2, 7'h0, 7'h3);
    fm[2] = 32'h41400000;
    exec(OP_FST, W8, 7'hf, 7'h2);
    chk_val(7'hf, 32'h41400000);
    exec(OP_FST, W8, 7'hf, 7'h3);
    chk_val(7'hf, 32'h40400000);
    tally_and_finish;
  end
endmodule
